// file: pin_mux_defs.svh
// Field positions, reset values and strap-free defaults of the host pin mux.
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// Reset values of the three configuration registers.
`define OPTC_RST        8'h00
`define LDEV9_RST       8'h00
`define GLOBAL_RST      8'h00

// Select fields of the pin option register C.
`define OPTC_IRQ14_FLD  1:0
`define OPTC_IRQ15_FLD  3:2
`define OPTC_DMA0_ACK_IN_FLD  5:4
`define OPTC_DMA0_REQ_OUT_FLD   7:6

// Single bits of the other two registers.
`define LDEV9_GPIO_BIT  2
`define GLOBAL_CLK48_BIT 6

// Output enables of the eight low and three high interrupt pins in interrupt mode.
`define IRQ_LO_ALL_OE   8'hff
`define IRQ_HI_ALL_OE   3'h7

`endif

// file: pin_mux_pkg.sv
// Types shared by the host pin mux and its DMA channel slices.
package pin_mux_pkg;

    // Two-bit pin select code; the meaning of each code depends on the pin.
    typedef enum logic [1:0] {
        SEL_PRIMARY = 2'h0,
        SEL_GPIO    = 2'h1,
        SEL_THIRD   = 2'h2,
        SEL_FOURTH  = 2'h3
    } pin_sel_t;

    // Whole state of the mux top.
    typedef struct packed {
        logic [7:0] opt_c;
        logic [7:0] ldev9;
        logic [7:0] glob;
        logic [3:0] mux_out;
        logic [3:0] mux_oe;
        logic [7:0] lo_out;
        logic [7:0] lo_oe;
        logic [2:0] hi_out;
        logic [2:0] hi_oe;
        logic [3:0] gpio1_in;
        logic [3:0] kbd_in;
        logic [7:0] gpio3_in;
        logic       gpio2_bit6_in;
        logic       serirq_in;
        logic       pci_clk;
    } mux_state_t;

    // Whole state of one DMA channel slice.
    typedef struct packed {
        logic drq;
        logic ack;
        logic done;
        logic hold;
    } dma_state_t;

endpackage

// file: dma_chan.sv
// One DMA channel: request to the host, acknowledge and terminal count back.
`timescale 1ns/100ps
`include "pin_mux_defs.svh"

module dma_chan
    import pin_mux_pkg::*;
(
    // Clock and reset.
    input  wire logic CLOCK_I,
    input  wire logic SYS_RST_I,
    // Internal side.
    input  wire logic req_i,
    output logic      ack_o,
    output logic      done_o,
    // Pin side.
    input  wire logic ack_pin_i,
    input  wire logic tc_pin_i,
    output logic      drq_o
);

    dma_state_t q;
    dma_state_t d;
    logic       tc_hit;

    // A terminal count only counts while the host acknowledges this channel.
    assign tc_hit = ack_pin_i & tc_pin_i;

    // The request is withheld after a terminal count until the source drops
    // it, so a stale request cannot start a transfer the host already ended.
    always_comb begin
        d      = q;
        d.ack  = ack_pin_i;
        d.done = tc_hit;
        d.hold = tc_hit | (q.hold & req_i);
        d.drq  = req_i & ~tc_hit & ~q.hold;
    end

    // State register.
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign drq_o  = q.drq;
    assign ack_o  = q.ack;
    assign done_o = q.done;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_tc_seen;
        ack_pin_i && tc_pin_i;
    endsequence

    sequence s_req_kept;
        req_i [*2];
    endsequence

    a_tc_drops_req: assert property (s_tc_seen |=> !drq_o && done_o)
        else $error("Request still up after terminal count.");

    a_hold_after_tc: assert property (s_tc_seen ##1 s_req_kept |-> !drq_o)
        else $error("Request resumed before the source released it.");

    a_req_follows: assert property (!q.hold && req_i && !tc_hit |=> drq_o)
        else $error("Request not passed to the pin.");

endmodule

// file: host_side_pin_function_mux.sv
// Pin-function mux for the shared host-side pins, with the DMA channels.
`timescale 1ns/100ps
`include "pin_mux_defs.svh"

// What this block does
// - Option C bits 5:4 pick DMA0 acknowledge, GPIO1 bit6/watchdog, or keyboard bit5.
// - Option C bits 7:6 pick DMA0 request, GPIO1 bit7/LED, keyboard bit4, ACPI event.
// - ACPI event pin pulls low, open drain, on power events in ACPI mode.
// - Option C bits 1:0 pick IRQ14, GPIO1 bit4 with alternates, or power LED.
// - Option C bits 3:2 pick IRQ15, GPIO1 bit5 with alternates, or watchdog.
// - Device 9 bit 2 turns IRQ 1 and 3-9 pins into GPIO3 bits 0-7.
// - Device 9 bit 2 makes IRQ10 serial IRQ and IRQ11 a PCI clock input.
// - Device 9 bit 2 makes IRQ12 GPIO2 bit 6, else it drives IRQ12.
// - DMA channels 1-3 have fixed request outputs and acknowledge inputs.
// - Reference clock is 24 or 48 MHz, chosen by global option bit 6.
module host_side_pin_function_mux
    import pin_mux_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    // Configuration writes and readback.
    input  wire logic [7:0]  CFG_WDATA_I,
    input  wire logic        OPT_C_WE_I,
    input  wire logic        LDEV9_CFG_WE_I,
    input  wire logic        GLOBAL_OPT_WE_I,
    output logic      [7:0]  PIN_OPTION_REG_C_O,
    output logic      [7:0]  LDEV9_IRQ_PIN_CFG_O,
    output logic      [7:0]  GLOBAL_OPTION_REG_O,
    output logic             REF_CLK_48_SEL_O,
    // Internal DMA and interrupt sources.
    input  wire logic [3:0]  DMA_REQ_I,
    output logic      [3:0]  DMA_ACK_O,
    output logic      [3:0]  DMA_DONE_O,
    input  wire logic [15:0] IRQ_REQ_I,
    // Internal GPIO port 1 bits 7:4 and their alternate selects.
    input  wire logic [3:0]  GPIO1_OUT_I,
    input  wire logic [3:0]  GPIO1_OE_I,
    input  wire logic [3:0]  GPIO1_ALT1_I,
    input  wire logic [1:0]  GPIO1_ALT2_I,
    output logic      [3:0]  GPIO1_IN_O,
    // Alternate function sources.
    input  wire logic        WATCHDOG_I,
    input  wire logic        POWER_LED_I,
    input  wire logic        ADDR_DECODE_I,
    input  wire logic        ADDR_WRITE_EN_I,
    input  wire logic        ACPI_MODE_I,
    input  wire logic        PM_EVENT_I,
    // Keyboard port bits, index 0..3 = bits 2, 4, 5, 7.
    input  wire logic [3:0]  KBD_OUT_I,
    input  wire logic [3:0]  KBD_OE_I,
    output logic      [3:0]  KBD_IN_O,
    // GPIO port 3, GPIO2 bit 6, serial IRQ and PCI clock.
    input  wire logic [7:0]  GPIO3_OUT_I,
    input  wire logic [7:0]  GPIO3_OE_I,
    output logic      [7:0]  GPIO3_IN_O,
    input  wire logic        GPIO2_B6_OUT_I,
    input  wire logic        GPIO2_B6_OE_I,
    output logic             GPIO2_B6_IN_O,
    input  wire logic        SERIRQ_OUT_I,
    input  wire logic        SERIRQ_OE_I,
    output logic             SERIRQ_IN_O,
    output logic             PCI_CLK_O,
    // Shared pins: DMA0 acknowledge, DMA0 request, IRQ14, IRQ15.
    input  wire logic        PIN_DMA0_ACK_IN_I,
    output logic             PIN_DMA0_ACK_IN_O,
    output logic             PIN_DMA0_ACK_IN_OE_O,
    input  wire logic        PIN_DMA0_REQ_OUT_I,
    output logic             PIN_DMA0_REQ_OUT_O,
    output logic             PIN_DMA0_REQ_OUT_OE_O,
    input  wire logic        PIN_IRQ14_I,
    output logic             PIN_IRQ14_O,
    output logic             PIN_IRQ14_OE_O,
    input  wire logic        PIN_IRQ15_I,
    output logic             PIN_IRQ15_O,
    output logic             PIN_IRQ15_OE_O,
    // IRQ 1,3..9 pins, bit 0 = IRQ1, bit k = IRQ(k+2).
    input  wire logic [7:0]  PIN_IRQ_LO_I,
    output logic      [7:0]  PIN_IRQ_LO_O,
    output logic      [7:0]  PIN_IRQ_LO_OE_O,
    // IRQ 10..12 pins, bit 0 = IRQ10.
    input  wire logic [2:0]  PIN_IRQ_HI_I,
    output logic      [2:0]  PIN_IRQ_HI_O,
    output logic      [2:0]  PIN_IRQ_HI_OE_O,
    // Dedicated DMA pins, channels 3..1, and terminal count.
    input  wire logic [3:1]  PIN_DACK_I,
    output logic      [3:1]  PIN_DRQ_O,
    input  wire logic        PIN_TC_I
);

    mux_state_t q;
    mux_state_t d;
    pin_sel_t   sel_dma0_ack_in;
    pin_sel_t   sel_dma0_req_out;
    pin_sel_t   sel_irq14;
    pin_sel_t   sel_irq15;
    logic       gpio_mode;
    logic [3:0] ack_pins;
    logic [3:0] dma_drq;

    // Output enable and level for a GPIO bit with up to two alternates;
    // alternate 1 wins over alternate 2, which wins over plain GPIO.
    function automatic logic [1:0] gpio_drive(
        input logic gout, input logic goe,
        input logic alt1, input logic a1v,
        input logic alt2, input logic a2o, input logic a2oe);
        logic [1:0] r;
        r = {goe, gout};
        if (alt1) begin
            r = {1'b1, a1v};
        end else if (alt2) begin
            r = {a2oe, a2o};
        end
        return r;
    endfunction

    // Select decode straight from the configuration flops.
    assign sel_dma0_ack_in = pin_sel_t'(q.opt_c[`OPTC_DMA0_ACK_IN_FLD]);
    assign sel_dma0_req_out  = pin_sel_t'(q.opt_c[`OPTC_DMA0_REQ_OUT_FLD]);
    assign sel_irq14 = pin_sel_t'(q.opt_c[`OPTC_IRQ14_FLD]);
    assign sel_irq15 = pin_sel_t'(q.opt_c[`OPTC_IRQ15_FLD]);
    assign gpio_mode = q.ldev9[`LDEV9_GPIO_BIT];

    // DMA0 only sees the acknowledge while its pin is in DMA mode.
    assign ack_pins = {PIN_DACK_I, PIN_DMA0_ACK_IN_I & (sel_dma0_ack_in == SEL_PRIMARY)};

    // One slice per channel; channel 0 shares its pins, 1-3 are fixed.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_dma
            dma_chan u_chan (
                .CLOCK_I   (CLOCK_I),
                .SYS_RST_I (SYS_RST_I),
                .req_i     (DMA_REQ_I[gi]),
                .ack_o     (DMA_ACK_O[gi]),
                .done_o    (DMA_DONE_O[gi]),
                .ack_pin_i (ack_pins[gi]),
                .tc_pin_i  (PIN_TC_I),
                .drq_o     (dma_drq[gi])
            );
        end
    endgenerate

    // Next state: configuration writes, then every pin's drive and input.
    // All pin drives are registered so a select change never glitches a pin.
    always_comb begin
        d = q;
        if (OPT_C_WE_I) begin
            d.opt_c = CFG_WDATA_I;
        end
        if (LDEV9_CFG_WE_I) begin
            d.ldev9 = CFG_WDATA_I;
        end
        if (GLOBAL_OPT_WE_I) begin
            d.glob = CFG_WDATA_I;
        end
        d.mux_out = 4'h0;
        d.mux_oe  = 4'h0;
        unique case (sel_dma0_ack_in)
            SEL_PRIMARY: ;
            SEL_GPIO: {d.mux_oe[0], d.mux_out[0]} = gpio_drive(GPIO1_OUT_I[2],
                GPIO1_OE_I[2], GPIO1_ALT1_I[2], WATCHDOG_I, 1'b0, 1'b0, 1'b0);
            SEL_THIRD: {d.mux_oe[0], d.mux_out[0]} = {KBD_OE_I[2], KBD_OUT_I[2]};
            SEL_FOURTH: ;
        endcase
        unique case (sel_dma0_req_out)
            SEL_PRIMARY: {d.mux_oe[1], d.mux_out[1]} = {1'b1, dma_drq[0]};
            SEL_GPIO: {d.mux_oe[1], d.mux_out[1]} = gpio_drive(GPIO1_OUT_I[3],
                GPIO1_OE_I[3], GPIO1_ALT1_I[3], POWER_LED_I, 1'b0, 1'b0, 1'b0);
            SEL_THIRD: {d.mux_oe[1], d.mux_out[1]} = {KBD_OE_I[1], KBD_OUT_I[1]};
            SEL_FOURTH: d.mux_oe[1] = ACPI_MODE_I & PM_EVENT_I;
        endcase
        unique case (sel_irq14)
            SEL_PRIMARY: {d.mux_oe[2], d.mux_out[2]} = {1'b1, IRQ_REQ_I[14]};
            SEL_GPIO: {d.mux_oe[2], d.mux_out[2]} = gpio_drive(GPIO1_OUT_I[0],
                GPIO1_OE_I[0], GPIO1_ALT1_I[0], ADDR_DECODE_I,
                GPIO1_ALT2_I[0], KBD_OUT_I[3], KBD_OE_I[3]);
            SEL_THIRD: {d.mux_oe[2], d.mux_out[2]} = {1'b1, POWER_LED_I};
            SEL_FOURTH: ;
        endcase
        unique case (sel_irq15)
            SEL_PRIMARY: {d.mux_oe[3], d.mux_out[3]} = {1'b1, IRQ_REQ_I[15]};
            SEL_GPIO: {d.mux_oe[3], d.mux_out[3]} = gpio_drive(GPIO1_OUT_I[1],
                GPIO1_OE_I[1], GPIO1_ALT1_I[1], ADDR_WRITE_EN_I,
                GPIO1_ALT2_I[1], KBD_OUT_I[0], KBD_OE_I[0]);
            SEL_THIRD: {d.mux_oe[3], d.mux_out[3]} = {1'b1, WATCHDOG_I};
            SEL_FOURTH: ;
        endcase
        // Pin inputs reach a function only while the pin is given to it.
        d.gpio1_in = {PIN_DMA0_REQ_OUT_I & (sel_dma0_req_out == SEL_GPIO),
                      PIN_DMA0_ACK_IN_I & (sel_dma0_ack_in == SEL_GPIO),
                      PIN_IRQ15_I & (sel_irq15 == SEL_GPIO),
                      PIN_IRQ14_I & (sel_irq14 == SEL_GPIO)};
        d.kbd_in = {PIN_IRQ14_I & (sel_irq14 == SEL_GPIO),
                    PIN_DMA0_ACK_IN_I & (sel_dma0_ack_in == SEL_THIRD),
                    PIN_DMA0_REQ_OUT_I & (sel_dma0_req_out == SEL_THIRD),
                    PIN_IRQ15_I & (sel_irq15 == SEL_GPIO)};
        // Interrupt pins or GPIO, serial IRQ and PCI clock.
        if (gpio_mode) begin
            d.lo_out    = GPIO3_OUT_I;
            d.lo_oe     = GPIO3_OE_I;
            d.gpio3_in  = PIN_IRQ_LO_I;
            d.hi_out    = {GPIO2_B6_OUT_I, 1'b0, SERIRQ_OUT_I};
            d.hi_oe     = {GPIO2_B6_OE_I, 1'b0, SERIRQ_OE_I};
            d.serirq_in = PIN_IRQ_HI_I[0];
            d.pci_clk   = PIN_IRQ_HI_I[1];
            d.gpio2_bit6_in   = PIN_IRQ_HI_I[2];
        end else begin
            d.lo_out    = {IRQ_REQ_I[9:3], IRQ_REQ_I[1]};
            d.lo_oe     = `IRQ_LO_ALL_OE;
            d.gpio3_in  = 8'h00;
            d.hi_out    = IRQ_REQ_I[12:10];
            d.hi_oe     = `IRQ_HI_ALL_OE;
            d.serirq_in = 1'b0;
            d.pci_clk   = 1'b0;
            d.gpio2_bit6_in   = 1'b0;
        end
    end

    // State register; master reset restores every select default.
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q <= '{opt_c: `OPTC_RST, ldev9: `LDEV9_RST,
                   glob: `GLOBAL_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    // Outputs, all from flops.
    assign PIN_OPTION_REG_C_O  = q.opt_c;
    assign LDEV9_IRQ_PIN_CFG_O = q.ldev9;
    assign GLOBAL_OPTION_REG_O = q.glob;
    assign REF_CLK_48_SEL_O    = q.glob[`GLOBAL_CLK48_BIT];
    assign GPIO1_IN_O          = q.gpio1_in;
    assign KBD_IN_O            = q.kbd_in;
    assign GPIO3_IN_O          = q.gpio3_in;
    assign GPIO2_B6_IN_O       = q.gpio2_bit6_in;
    assign SERIRQ_IN_O         = q.serirq_in;
    assign PCI_CLK_O           = q.pci_clk;
    assign {PIN_IRQ15_O, PIN_IRQ14_O, PIN_DMA0_REQ_OUT_O, PIN_DMA0_ACK_IN_O} = q.mux_out;
    assign {PIN_IRQ15_OE_O, PIN_IRQ14_OE_O, PIN_DMA0_REQ_OUT_OE_O, PIN_DMA0_ACK_IN_OE_O} =
        q.mux_oe;
    assign PIN_IRQ_LO_O        = q.lo_out;
    assign PIN_IRQ_LO_OE_O     = q.lo_oe;
    assign PIN_IRQ_HI_O        = q.hi_out;
    assign PIN_IRQ_HI_OE_O     = q.hi_oe;
    assign PIN_DRQ_O           = dma_drq[3:1];

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    a_dma0_ack_in_input: assert property (sel_dma0_ack_in == SEL_PRIMARY |=> !PIN_DMA0_ACK_IN_OE_O)
        else $error("DMA0 acknowledge pin driven in DMA mode.");

    a_dma0_req_out_route: assert property (sel_dma0_req_out == SEL_PRIMARY |=>
        PIN_DMA0_REQ_OUT_OE_O && PIN_DMA0_REQ_OUT_O == $past(dma_drq[0]))
        else $error("DMA0 request not on its pin.");

    a_acpi_pull: assert property (sel_dma0_req_out == SEL_FOURTH && ACPI_MODE_I &&
        PM_EVENT_I |=> PIN_DMA0_REQ_OUT_OE_O && !PIN_DMA0_REQ_OUT_O)
        else $error("ACPI event not pulled low.");

    a_acpi_release: assert property (sel_dma0_req_out == SEL_FOURTH &&
        !(ACPI_MODE_I && PM_EVENT_I) |=> !PIN_DMA0_REQ_OUT_OE_O)
        else $error("ACPI event pin driven without an event.");

    a_irq14_route: assert property (sel_irq14 == SEL_THIRD |=>
        PIN_IRQ14_OE_O && PIN_IRQ14_O == $past(POWER_LED_I))
        else $error("Power LED not on IRQ14 pin.");

    a_irq15_float: assert property (sel_irq15 == SEL_FOURTH |=>
        !PIN_IRQ15_OE_O)
        else $error("IRQ15 pin driven on unused code.");

    a_irq_lo_route: assert property (!gpio_mode |=> PIN_IRQ_LO_OE_O == 8'hff
        && PIN_IRQ_LO_O == $past({IRQ_REQ_I[9:3], IRQ_REQ_I[1]}))
        else $error("Interrupt requests not on the low IRQ pins.");

    a_gpio_mode_hi: assert property (gpio_mode |=> !PIN_IRQ_HI_OE_O[1] &&
        PIN_IRQ_HI_OE_O[2] == $past(GPIO2_B6_OE_I) &&
        PCI_CLK_O == $past(PIN_IRQ_HI_I[1]))
        else $error("High IRQ pins not in GPIO mode.");

endmodule

// file: isa_host_model.sv
// Behavioural ISA host chipset that answers DMA requests.
`timescale 1ns/100ps

module isa_host_model (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Behaviour chosen by the bench.
    input  wire logic [3:0] delay_i,
    input  wire logic       give_tc_i,
    // DMA pins, channel 0 first.
    input  wire logic [3:0] drq_i,
    output logic      [3:0] dack_o,
    output logic            tc_o
);
    logic [3:0] cnt_q;
    logic [3:0] served_q;
    logic [3:0] want;
    logic [3:0] pick;

    // Lowest waiting channel wins the grant.
    assign want = drq_i & ~served_q;
    assign pick = want & (~want + 4'h1);

    // One grant at a time, held one cycle, with terminal count if asked.
    // A served channel is not granted again until its request drops,
    // so a request that never ends is not acknowledged twice.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dack_o   <= 4'h0;
            tc_o     <= 1'b0;
            cnt_q    <= 4'h0;
            served_q <= 4'h0;
        end else begin
            dack_o   <= 4'h0;
            tc_o     <= 1'b0;
            served_q <= served_q & drq_i;
            if (want != 4'h0 && dack_o == 4'h0) begin
                if (cnt_q >= delay_i) begin
                    dack_o   <= pick;
                    tc_o     <= give_tc_i;
                    served_q <= (served_q & drq_i) | pick;
                    cnt_q    <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule

// file: host_side_pin_function_mux_tb_top.sv
// Self-checking bench for the host pin mux with an ISA host model.
`timescale 1ns/100ps

module host_side_pin_function_mux_tb_top;
    // Clock, reset and configuration strobes.
    logic clk = 1'b0, rst = 1'b1, we_c = 1'b0, we_9 = 1'b0, we_g = 1'b0;
    logic [7:0] wdata = 8'h00, g3_out = 8'h35, g3_oe = 8'h0f, lo_ext = 8'hc3;
    logic [15:0] irq_req = 16'h5a5a;
    logic [3:0] dma_req = 4'h0, g1_out = 4'h5, g1_oe = 4'hf, g1_alt1 = 4'h0;
    logic [3:0] kbd_out = 4'ha, kbd_oe = 4'hf, host_dly = 4'h0;
    logic wd = 1'b0, led = 1'b1, adec = 1'b1, awe = 1'b1, acpi = 1'b1;
    logic pme = 1'b1, g26_out = 1'b1, g26_oe = 1'b1, sq_out = 1'b0;
    logic sq_oe = 1'b1, pci_ext = 1'b0, host_tc = 1'b1;
    // Design outputs and pin levels.
    logic [7:0] rd_c, rd_9, rd_g, g3_in, lo_i, lo_o, lo_oe;
    logic [3:0] dma_ack, dma_done, g1_in, host_ack, kbd_in;
    logic [2:0] hi_i, hi_o, hi_oe;
    logic [3:1] drq_pin;
    logic clk48, g26_in, sq_in, pci_clk, tc_pin;
    logic dk0_i, dk0_o, dk0_oe, dq0_i, dq0_o, dq0_oe;
    logic i14_i, i14_o, i14_oe, i15_i, i15_o, i15_oe;
    logic [7:0] mux_vec;
    logic [3:0] drq_all;
    int mismatches = 0;
    int total_checks = 0;
    logic [7:0] exp_mux [5] = '{8'he2, 8'hee, 8'heb, 8'h02, 8'hfb};

    always #10 clk = ~clk;

    // Wire levels: undriven DMA0 request, IRQ14 and IRQ15 pins float high; the others take the host or external level.
    assign dk0_i = dk0_oe ? dk0_o : host_ack[0];
    assign dq0_i = dq0_oe ? dq0_o : 1'b1;
    assign i14_i = i14_oe ? i14_o : 1'b1;
    assign i15_i = i15_oe ? i15_o : 1'b1;
    assign lo_i = (lo_oe & lo_o) | (~lo_oe & lo_ext);
    assign hi_i = (hi_oe & hi_o) | (~hi_oe & {1'b1, pci_ext, 1'b1});
    // Output value only counts where the pin is driven.
    assign mux_vec = {i14_oe, i14_o & i14_oe, i15_oe, i15_o & i15_oe,
                      dk0_oe, dk0_o & dk0_oe, dq0_oe, dq0_o & dq0_oe};
    assign drq_all = {drq_pin, dq0_oe & dq0_o};

    host_side_pin_function_mux i_host_side_pin_function_mux (
        .CLOCK_I(clk), .SYS_RST_I(rst), .CFG_WDATA_I(wdata),
        .OPT_C_WE_I(we_c), .LDEV9_CFG_WE_I(we_9), .GLOBAL_OPT_WE_I(we_g),
        .PIN_OPTION_REG_C_O(rd_c), .LDEV9_IRQ_PIN_CFG_O(rd_9),
        .GLOBAL_OPTION_REG_O(rd_g), .REF_CLK_48_SEL_O(clk48),
        .DMA_REQ_I(dma_req), .DMA_ACK_O(dma_ack), .DMA_DONE_O(dma_done),
        .IRQ_REQ_I(irq_req), .GPIO1_OUT_I(g1_out), .GPIO1_OE_I(g1_oe),
        .GPIO1_ALT1_I(g1_alt1), .GPIO1_ALT2_I(2'h0), .GPIO1_IN_O(g1_in),
        .WATCHDOG_I(wd), .POWER_LED_I(led), .ADDR_DECODE_I(adec),
        .ADDR_WRITE_EN_I(awe), .ACPI_MODE_I(acpi), .PM_EVENT_I(pme),
        .KBD_OUT_I(kbd_out), .KBD_OE_I(kbd_oe), .KBD_IN_O(kbd_in),
        .GPIO3_OUT_I(g3_out), .GPIO3_OE_I(g3_oe), .GPIO3_IN_O(g3_in),
        .GPIO2_B6_OUT_I(g26_out), .GPIO2_B6_OE_I(g26_oe),
        .GPIO2_B6_IN_O(g26_in), .SERIRQ_OUT_I(sq_out), .SERIRQ_OE_I(sq_oe),
        .SERIRQ_IN_O(sq_in), .PCI_CLK_O(pci_clk),
        .PIN_DMA0_ACK_IN_I(dk0_i), .PIN_DMA0_ACK_IN_O(dk0_o), .PIN_DMA0_ACK_IN_OE_O(dk0_oe),
        .PIN_DMA0_REQ_OUT_I(dq0_i), .PIN_DMA0_REQ_OUT_O(dq0_o), .PIN_DMA0_REQ_OUT_OE_O(dq0_oe),
        .PIN_IRQ14_I(i14_i), .PIN_IRQ14_O(i14_o), .PIN_IRQ14_OE_O(i14_oe),
        .PIN_IRQ15_I(i15_i), .PIN_IRQ15_O(i15_o), .PIN_IRQ15_OE_O(i15_oe),
        .PIN_IRQ_LO_I(lo_i), .PIN_IRQ_LO_O(lo_o), .PIN_IRQ_LO_OE_O(lo_oe),
        .PIN_IRQ_HI_I(hi_i), .PIN_IRQ_HI_O(hi_o), .PIN_IRQ_HI_OE_O(hi_oe),
        .PIN_DACK_I(host_ack[3:1]), .PIN_DRQ_O(drq_pin), .PIN_TC_I(tc_pin)
    );

    isa_host_model i_isa_host_model (
        .clk_i(clk), .rst_i(rst), .delay_i(host_dly), .give_tc_i(host_tc),
        .drq_i(drq_all), .dack_o(host_ack), .tc_o(tc_pin)
    );

    // Compare one value and report at once when it differs.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Write one register: 0 option C, 1 device 9, 2 global; then settle.
    task automatic wr(input int which, input logic [7:0] d);
        @(negedge clk);
        wdata = d;
        we_c = (which == 0);
        we_9 = (which == 1);
        we_g = (which == 2);
        @(negedge clk);
        {we_c, we_9, we_g} = 3'h0;
        repeat (3) @(negedge clk);
    endtask

    // One DMA transfer on a channel; the wait is bounded by 40 cycles.
    task automatic dma(input int ch, input logic [3:0] dly, input logic tc);
        int n;
        @(negedge clk);
        host_dly = dly;
        host_tc = tc;
        dma_req[ch] = 1'b1;
        n = 0;
        while (dma_done[ch] !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(n < 40, tc, "done pulse");
        if (tc) begin
            check(dma_ack[ch], 1'b1, "ack with done");
            repeat (3) @(negedge clk);
            check(drq_all[ch], 1'b0, "request held off");
        end else begin
            check(drq_all[ch], 1'b1, "request kept");
        end
        dma_req[ch] = 1'b0;
        repeat (4) @(negedge clk);
        check(drq_all[ch], 1'b0, "request idle");
    endtask

    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check({rd_c, rd_9}, 16'h0000, "reset config");
        check(mux_vec, 8'he2, "default pins");
        check({lo_oe, lo_o}, {8'hff, irq_req[9:3], irq_req[1]}, "irq lo");
        check({hi_oe, hi_o}, {3'h7, irq_req[12:10]}, "irq hi");
        $display("test defaults done");
        // Every select code on all four fields, plus alternate 1.
        for (int k = 0; k < 5; k++) begin
            logic [1:0] c;
            c = (k == 4) ? 2'h1 : k[1:0];
            g1_alt1 = (k == 4) ? 4'hf : 4'h0;
            wr(0, {4{c}});
            check(rd_c, {4{c}}, "option c readback");
            check(mux_vec, exp_mux[k], "pin mux");
            if (k == 1) check(g1_in, 4'h5, "gpio1 in");
            if (k == 1) check(kbd_in, 4'h8, "kbd in gpio");
            if (k == 2) check(kbd_in, 4'h2, "kbd in port");
            if (k == 3) begin
                pme = 1'b0;
                repeat (2) @(negedge clk);
                check(dq0_oe, 1'b0, "event idle");
                {acpi, pme} = 2'b01;
                repeat (2) @(negedge clk);
                check(dq0_oe, 1'b0, "not acpi mode");
                acpi = 1'b1;
            end
        end
        wr(0, 8'h00);
        $display("test pin select done");
        wr(1, 8'h04);
        check({lo_oe, lo_oe & lo_o}, {g3_oe, g3_oe & g3_out}, "gpio3 pins");
        check(g3_in, (g3_oe & g3_out) | (~g3_oe & lo_ext), "gpio3 in");
        check({hi_oe, hi_oe & hi_o}, 6'h2c, "serial irq and gpio2");
        pci_ext = 1'b1;
        repeat (2) @(negedge clk);
        check(pci_clk, 1'b1, "pci clock high");
        {pci_ext, sq_oe} = 2'b00;
        repeat (2) @(negedge clk);
        check({pci_clk, sq_in, g26_in}, 3'h3, "pci low, serial irq in");
        wr(1, 8'h00);
        $display("test device 9 done");
        wr(2, 8'h40);
        check({rd_g, clk48}, {8'h40, 1'b1}, "48 MHz");
        wr(2, 8'hbf);
        check({rd_g, clk48}, {8'hbf, 1'b0}, "24 MHz");
        $display("test clock select done");
        for (int ch = 0; ch < 4; ch++) dma(ch, 4'h0, 1'b1);
        dma(2, 4'h6, 1'b1);
        dma(1, 4'h2, 1'b0);
        $display("test dma done");
        wr(0, 8'hff);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check({rd_c, rd_g}, 16'h0000, "mid-run reset");
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(mux_vec, 8'he2, "defaults again");
        $display("test second reset done");
        close_out();
    end
endmodule
